// >>> shared/vtid_pkg.sv
// Package for the video test and identification unit: indexed register map,
// field positions, reset values and the signature polynomial.
// Assumes the indexed 8-bit host port of the palette device supplies index and data.
package vtid_pkg;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_SILICON_REVISION  = 8'h01;
  localparam logic [7:0] IDX_SENSE_STATUS      = 8'h3A;
  localparam logic [7:0] IDX_SIG_REMAINDER_LO  = 8'h3C;
  localparam logic [7:0] IDX_SIG_REMAINDER_HI  = 8'h3D;
  localparam logic [7:0] IDX_SIG_LINE_SELECT   = 8'h3E;
  localparam logic [7:0] IDX_DEVICE_IDENTITY   = 8'h3F;

  // ----------------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------------
  localparam int         SENSE_DISABLE_BIT     = 7;
  localparam int         SENSE_RED_BIT         = 2;
  localparam int         SENSE_GREEN_BIT       = 1;
  localparam int         SENSE_BLUE_BIT        = 0;
  localparam logic [4:0] SIG_LINE_MAX          = 5'h17;
  localparam int         SIG_LINES             = 24;
  localparam logic [4:0] SIG_LINE_RESET        = 5'h00;
  localparam logic [15:0] SIG_POLY             = 16'h1021;
  localparam logic [15:0] SIG_SEED             = 16'h0000;
  localparam logic [7:0] DEVICE_CODE_DEFAULT   = 8'h5A; // Arbitrary value.
  localparam logic [7:0] REVISION_DEFAULT      = 8'h10; // Arbitrary value.

  // Host register access carried as one bundle.
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } vtid_host_req_t;

  // Video timing inputs sampled on the dot clock.
  typedef struct packed
  {
    logic system_blank_in;
    logic legacy_port_blank_in;
    logic hsync_n;
  } vtid_video_t;

endpackage

// >>> src/vtid_unit.sv
// Test and identification logic: line signature, sense comparators, ID and revision.
// Assumes all inputs are synchronous to the dot clock and blank is active low.
`timescale 1ns/1ns
module vtid_unit
#(
  parameter logic [7:0] DEVICE_CODE = vtid_pkg::DEVICE_CODE_DEFAULT, // Arbitrary value.
  parameter logic [7:0] REVISION    = vtid_pkg::REVISION_DEFAULT     // Arbitrary value.
)
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire vtid_pkg::vtid_host_req_t host_req,
  output logic [7:0]                    host_rdata,
  input  wire vtid_pkg::vtid_video_t    video,
  input  wire logic                     blank_source_select,
  input  wire logic [23:0]              dac_data,
  input  wire logic                     red_current_out,
  input  wire logic                     green_current_out,
  input  wire logic                     blue_current_out,
  output logic                          sense_n,
  output logic                          frame_valid
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    VTID_WAIT  = 3'b001,   // Retrace handled; hsync ignored until active area.
    VTID_ACCUM = 3'b010,   // Accumulating a frame.
    VTID_ONE   = 3'b100    // Blank seen, one hsync counted.
  } vtid_state_t;

  vtid_state_t state, next_state;
  logic        seen_frame, next_seen_frame;
  logic [15:0] crc, next_crc;
  logic [15:0] remainder, next_remainder;
  logic        hs_d, blank_d;
  logic [4:0]  line_sel, next_line_sel;
  logic        compare_disable, next_compare_disable;
  logic [2:0]  sense_bits, next_sense_bits;
  logic        next_sense_n;
  logic        next_frame_valid;
  logic [7:0]  next_rdata;

  logic blank_n;
  logic hs_fall;
  logic blank_fall;
  logic in_bit;

  // Blank chosen by the source select, then its falling edge.
  assign blank_n    = blank_source_select ? video.legacy_port_blank_in
                                          : video.system_blank_in;
  assign blank_fall = blank_d & ~blank_n;
  // Hsync counted on its leading (falling) edge since it is active low.
  assign hs_fall    = hs_d & ~video.hsync_n;
  assign in_bit     = dac_data[line_sel];

  // ----------------------------------------------------------------------
  // Signature engine
  // ----------------------------------------------------------------------
  // Two hsync edges inside one blanking period mark vertical retrace;
  // horizontal blanking only ever holds one, so it cannot trigger an update.
  always_comb
  begin
    next_state      = state;
    next_crc        = crc;
    next_remainder  = remainder;
    next_seen_frame = seen_frame;
    if (blank_n)
    begin
      // Active area: serial shift with the fixed polynomial.
      next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ in_bit) ? vtid_pkg::SIG_POLY : 16'h0000);
      if (state == VTID_ONE || state == VTID_WAIT)
        next_state = VTID_ACCUM;
    end
    else if (hs_fall)
    begin
      unique case (state)
        // Later hsyncs of a long vertical blank must not retrigger an update.
        VTID_WAIT:
          next_state = VTID_WAIT;
        VTID_ACCUM:
          next_state = VTID_ONE;
        VTID_ONE:
        begin
          // Second hsync within blank: vertical retrace.
          if (seen_frame)
          begin
            next_remainder = crc;
          end
          next_seen_frame = 1'b1;
          next_crc        = vtid_pkg::SIG_SEED;
          next_state      = VTID_WAIT;
        end
      endcase
    end
  end

  // Frame valid rises only after a full retrace-to-retrace frame.
  assign next_frame_valid = frame_valid | (state == VTID_ONE && !blank_n && hs_fall && seen_frame);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state       <= VTID_WAIT;
      crc         <= vtid_pkg::SIG_SEED;
      remainder   <= vtid_pkg::SIG_SEED;
      seen_frame  <= 1'b0;
      frame_valid <= 1'b0;
      hs_d        <= 1'b1;
      blank_d     <= 1'b1;
    end
    else
    begin
      state       <= next_state;
      crc         <= next_crc;
      remainder   <= next_remainder;
      seen_frame  <= next_seen_frame;
      frame_valid <= next_frame_valid;
      hs_d        <= video.hsync_n;
      blank_d     <= blank_n;
    end
  end

  // ----------------------------------------------------------------------
  // Sense comparators
  // ----------------------------------------------------------------------
  // Results captured only at the blank falling edge so DAC levels are settled.
  always_comb
  begin
    next_sense_bits = sense_bits;
    next_sense_n    = sense_n;
    if (blank_fall && !compare_disable)
    begin
      next_sense_bits = {red_current_out, green_current_out, blue_current_out};
      next_sense_n    = ~(red_current_out | green_current_out | blue_current_out);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sense_bits <= 3'h0;
      sense_n    <= 1'b1;
    end
    else
    begin
      sense_bits <= next_sense_bits;
      sense_n    <= next_sense_n;
    end
  end

  // ----------------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------------
  // Out-of-range line selects are ignored so the mux never leaves 0..23.
  always_comb
  begin
    next_line_sel        = line_sel;
    next_compare_disable = compare_disable;
    if (host_req.wr)
    begin
      if (host_req.index == vtid_pkg::IDX_SIG_LINE_SELECT &&
          host_req.wdata[4:0] <= vtid_pkg::SIG_LINE_MAX && host_req.wdata[7:5] == 3'h0)
        next_line_sel = host_req.wdata[4:0];
      if (host_req.index == vtid_pkg::IDX_SENSE_STATUS)
        next_compare_disable = host_req.wdata[vtid_pkg::SENSE_DISABLE_BIT];
    end
  end

  // Read data registered on the read strobe; unmapped indices read zero.
  always_comb
  begin
    next_rdata = host_rdata;
    if (host_req.rd)
    begin
      unique case (host_req.index)
        vtid_pkg::IDX_SILICON_REVISION: next_rdata = REVISION;
        vtid_pkg::IDX_SENSE_STATUS:     next_rdata = {compare_disable, 4'h0, sense_bits};
        vtid_pkg::IDX_SIG_REMAINDER_LO: next_rdata = remainder[7:0];
        vtid_pkg::IDX_SIG_REMAINDER_HI: next_rdata = remainder[15:8];
        vtid_pkg::IDX_SIG_LINE_SELECT:  next_rdata = {3'h0, line_sel};
        vtid_pkg::IDX_DEVICE_IDENTITY:  next_rdata = DEVICE_CODE;
        default:                        next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      line_sel        <= vtid_pkg::SIG_LINE_RESET;
      compare_disable <= 1'b0;
      host_rdata      <= 8'h00;
    end
    else
    begin
      line_sel        <= next_line_sel;
      compare_disable <= next_compare_disable;
      host_rdata      <= next_rdata;
    end
  end

endmodule

// >>> bench/vtid_unit_properties.sv
// Port checker for vtid_unit.
// Bound to every vtid_unit; sees only its ports.
`timescale 1ns/1ns
module vtid_unit_properties
#(
  parameter logic [7:0] DEVICE_CODE = vtid_pkg::DEVICE_CODE_DEFAULT, // Arbitrary value.
  parameter logic [7:0] REVISION    = vtid_pkg::REVISION_DEFAULT     // Arbitrary value.
)
(
  input wire logic                     clk,
  input wire logic                     srst,
  input wire vtid_pkg::vtid_host_req_t host_req,
  input wire logic [7:0]               host_rdata,
  input wire vtid_pkg::vtid_video_t    video,
  input wire logic                     blank_source_select,
  input wire logic                     red_current_out,
  input wire logic                     green_current_out,
  input wire logic                     blue_current_out,
  input wire logic                     sense_n,
  input wire logic                     frame_valid
);
  // ------
  // Helpers
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic blk;
  logic blk_q;
  logic fall;
  logic any;
  // The selected blank and its falling edge, as the capture logic sees them.
  assign blk = blank_source_select ? video.legacy_port_blank_in : video.system_blank_in;
  assign fall = blk_q & ~blk;
  assign any = red_current_out | green_current_out | blue_current_out;
  always_ff @(posedge clk)
  begin
    blk_q <= blk;
  end
  sequence rd_at(logic [7:0] i);
    host_req.rd && host_req.index == i;
  endsequence
  a_id_code: assert property (rd_at(8'h3F) |=> host_rdata == DEVICE_CODE)
    else $error("identity read wrong");
  a_rev_code: assert property (rd_at(8'h01) |=> host_rdata == REVISION)
    else $error("revision read wrong");
  a_status_reserved: assert property (rd_at(8'h3A) |=> host_rdata[6:3] == 4'h0)
    else $error("reserved status bits set");
  a_select_range: assert property (rd_at(8'h3E) |=> host_rdata <= 8'h17)
    else $error("line select out of range");
  a_sense_low: assert property ($fell(sense_n) |-> $past(fall && any))
    else $error("sense fell without cause");
  a_sense_high: assert property ($rose(sense_n) |-> $past(fall && !any))
    else $error("sense rose without cause");
  a_rdata_hold: assert property ($changed(host_rdata) |-> $past(host_req.rd))
    else $error("read data moved without read");
  a_valid_sticky: assert property (frame_valid |=> frame_valid)
    else $error("frame valid dropped");
  a_valid_retrace: assert property ($rose(frame_valid) |-> $past(!blk))
    else $error("frame valid outside retrace");
endmodule
bind vtid_unit vtid_unit_properties #(.DEVICE_CODE(DEVICE_CODE), .REVISION(REVISION)) u_props
  (.clk, .srst, .host_req, .host_rdata, .video, .blank_source_select, .red_current_out,
   .green_current_out, .blue_current_out, .sense_n, .frame_valid);

// >>> bench/vtid_video_src.sv
// Video timing source model: blanks and active-low hsync.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
module vtid_video_src
(
  input wire logic           clk,
  output vtid_pkg::vtid_video_t video
);
  // ------
  // Timing
  // ------
  initial video = 3'b111;
  // Both blanks move together, so either source selection sees the same frame.
  task automatic seg(input logic b, input logic h, input int n);
    repeat (n) @(negedge clk) video = {b, b, h};
  endtask
  // One line: 20 active cycles, then blank holding the given hsync pulses.
  task automatic line(input int pulses);
    seg(1'b1, 1'b1, 20);
    repeat (pulses)
    begin
      seg(1'b0, 1'b1, 2);
      seg(1'b0, 1'b0, 2);
    end
    seg(1'b0, 1'b1, 2);
  endtask
  // Four lines of 20 active cycles, the last ending in a retrace blank holding
  // four hsync pulses; only the first pair may update the remainder.
  task automatic frame();
    repeat (3) line(1);
    line(4);
  endtask
  // Falling edge on one blank only, the other held high, to show the selector.
  task automatic fall_one(input logic legacy);
    repeat (2) @(negedge clk) video = 3'b111;
    repeat (3) @(negedge clk) video = {legacy, ~legacy, 1'b1};
  endtask
  task automatic fall();
    seg(1'b1, 1'b1, 2);
    seg(1'b0, 1'b1, 3);
  endtask
endmodule

// >>> bench/vtid_unit_tb.sv
// Self-checking bench for vtid_unit.
// Assumes the checker and video source model compile first.
`timescale 1ns/1ns
module vtid_unit_tb;
  logic clk;
  logic srst;
  vtid_pkg::vtid_host_req_t hreq;
  logic [7:0] rdata;
  vtid_pkg::vtid_video_t video;
  logic [23:0] dac;
  logic [2:0] rgb;
  logic sense_n;
  logic fvalid;
  logic bsel;
  int fails = 0;
  int checked = 0;
  logic [31:0] seed = 32'h00006C06;
  vtid_unit u_vtid_unit (.clk, .srst, .host_req(hreq), .host_rdata(rdata), .video,
    .blank_source_select(bsel), .dac_data(dac), .red_current_out(rgb[2]),
    .green_current_out(rgb[1]), .blue_current_out(rgb[0]), .sense_n, .frame_valid(fvalid));
  vtid_video_src u_vtid_video_src (.clk, .video);
  // ------
  // Helpers
  // ------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Remainder of 80 active cycles of a constant bit, from seed zero.
  function automatic logic [15:0] crc_of(input logic b);
    logic [15:0] c;
    c = vtid_pkg::SIG_SEED;
    repeat (80) c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? vtid_pkg::SIG_POLY : 16'h0000);
    return c;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk) hreq = '{1'b1, 1'b0, i, d};
    @(negedge clk) hreq = '0;
  endtask
  task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk) hreq = '{1'b0, 1'b1, i, 8'h00};
    @(negedge clk) hreq = '0;
    @(negedge clk) cmp(16'(rdata), 16'(e));
  endtask
  task automatic stop_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Registers, sense capture, then signature frames with random data.
  initial
  begin
    logic [4:0] s;
    logic [15:0] e;
    logic [31:0] r;
    hreq = '0;
    srst = 1'b1;
    dac = 24'h000000;
    rgb = 3'b000;
    bsel = 1'b0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    wr(8'h3F, 8'hFF);
    rd_chk(8'h3F, vtid_pkg::DEVICE_CODE_DEFAULT);
    rd_chk(8'h01, vtid_pkg::REVISION_DEFAULT);
    rd_chk(8'h20, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk) rgb = 3'(k);
      u_vtid_video_src.fall();
      cmp(16'(sense_n), 16'(k == 0));
      rd_chk(8'h3A, 8'(k));
    end
    wr(8'h3A, 8'h80);
    @(negedge clk) rgb = 3'b000;
    u_vtid_video_src.fall();
    cmp(16'(sense_n), 16'h0000);
    rd_chk(8'h3A, 8'h87);
    wr(8'h3A, 8'h00);
    u_vtid_video_src.fall();
    cmp(16'(sense_n), 16'h0001);
    // Legacy blank selected: a fall on the system blank alone must not capture.
    @(negedge clk) rgb = 3'b010;
    bsel = 1'b1;
    u_vtid_video_src.fall_one(1'b0);
    cmp(16'(sense_n), 16'h0001);
    u_vtid_video_src.fall_one(1'b1);
    cmp(16'(sense_n), 16'h0000);
    rd_chk(8'h3A, 8'h02);
    @(negedge clk) bsel = 1'b0;
    wr(8'h3E, 8'h18);
    rd_chk(8'h3E, 8'h00);
    u_vtid_video_src.frame();
    cmp(16'(fvalid), 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      s = (i == 0) ? 5'h17 : 5'(r % 32'd24);
      wr(8'h3E, {3'h0, s});
      rd_chk(8'h3E, {3'h0, s});
      dac = (i == 0) ? 24'hFFFFFF : r[31:8]; // Corner: all ones first.
      u_vtid_video_src.frame();
      e = crc_of(dac[s]);
      rd_chk(8'h3C, e[7:0]);
      rd_chk(8'h3D, e[15:8]);
      cmp(16'(fvalid), 16'h0001);
    end
    dac = ~dac;
    u_vtid_video_src.line(1);
    rd_chk(8'h3C, e[7:0]);
    stop_test();
  end
endmodule
